// ---- hw/ssc_map.svh ----
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH
// register byte offsets
`define SSC_OFF_CTRL 8'h00
`define SSC_OFF_SOURCE 8'h04
`define SSC_OFF_CMD 8'h08
`define SSC_OFF_INIT_CUR 8'h0c
`define SSC_OFF_MAX_CUR 8'h10
`define SSC_OFF_FLA 8'h14
`define SSC_OFF_RAMP_TIME 8'h18
`define SSC_OFF_UTS_TIME 8'h1c
`define SSC_OFF_STATUS 8'h20
`define SSC_OFF_CUR_REF 8'h24
// field positions
`define SSC_CTRL_LR_BIT 0
`define SSC_CTRL_KPDIS_BIT 1
`define SSC_CTRL_LRDIN_BIT 2
`define SSC_SRC_LOCAL_LSB 0
`define SSC_SRC_REMOTE_LSB 4
`define SSC_CMD_START_BIT 0
`define SSC_CMD_STOP_BIT 1
// source encodings
`define SSC_SRC_KEYPAD 2'h0
`define SSC_SRC_TERMINAL 2'h1
`define SSC_SRC_SERIAL 2'h2
// reset values and ranges
`define SSC_LR_LOCAL 1'h0
`define SSC_INIT_PCT_RST 10'h064
`define SSC_INIT_PCT_MIN 10'h032
`define SSC_INIT_PCT_MAX 10'h258
`define SSC_MAX_PCT_RST 10'h258
`define SSC_MAX_PCT_MIN 10'h064
`define SSC_MAX_PCT_MAX 10'h320
`define SSC_FLA_RST 16'h0064
`define SSC_RAMP_SEC_RST 9'h00f
`define SSC_RAMP_SEC_MAX 9'h12c
`define SSC_UTS_SEC_RST 9'h014
`define SSC_UTS_SEC_MIN 9'h001
`define SSC_UTS_SEC_MAX 9'h12c
`define SSC_PCT_FULL 26'h0000064
// timing
`define SSC_CLK_HZ 125000000
`define SSC_TICK_MS 1
`define SSC_MS_PER_S 1000
`define SSC_TICK_CYCLES (`SSC_CLK_HZ / 1000 * `SSC_TICK_MS)
`endif

// ---- hw/ssc_pkg.sv ----
package ssc_pkg;
  typedef enum logic [2:0] {
    SSC_IDLE,
    SSC_RAMP,
    SSC_HOLD,
    SSC_RUN,
    SSC_STALLED,
    SSC_TRIPPED
  } ssc_mode_type;
endpackage

// ---- hw/ssc_starter.sv ----
// Overview of operation
// - remote source picks keypad, terminal or serial; terminal after reset
// - with local/remote input assigned: low selects local, high selects remote
// - without assigned input the control register local/remote bit selects
// - local/remote bit resets to local
// - initial current accepts 50 to 600 percent, resets to 100
// - start command drives motor first at initial current scaled by full load amps
// - initial current is a percentage of full load amps, not amps
// - maximum current accepts 100 to 800 percent, resets to 600
// - maximum current ends the ramp and limits current afterwards
// - ramp over before full speed: hold maximum until speed, timer or trip
// - keypad stop works for every source; disabling it only affects terminal and serial sources
// - not up to speed when up-to-speed timer expires means stalled motor
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_starter
  import ssc_pkg::*;
#(
  parameter int TICK_CYCLES = `SSC_TICK_CYCLES,
  parameter int MS_PER_S = `SSC_MS_PER_S
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic localRemoteIn,
  input wire logic keypadStartKey,
  input wire logic keypadStopKey,
  input wire logic terminalStart,
  input wire logic terminalStop,
  input wire logic atSpeed,
  input wire logic tripIn,
  output logic motorRun,
  output logic upToSpeed,
  output logic stalled,
  output logic tripped,
  output logic remoteActive,
  output logic [1:0] activeSource,
  output logic [19:0] currentRef
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int PIN_N = 7;
  localparam int P_LR = 0;
  localparam int P_KSTA = 1;
  localparam int P_KSTO = 2;
  localparam int P_TSTA = 3;
  localparam int P_TSTO = 4;
  localparam int P_SPD = 5;
  localparam int P_TRIP = 6;

  if (TICK_CYCLES < 1 || MS_PER_S < 1 || MS_PER_S > 1023)
  begin : gCheck
    $error("ssc_starter: tick or millisecond count out of range");
  end

  typedef struct packed {
    logic [PIN_N-1:0] syncA;
    logic [PIN_N-1:0] syncB;
    logic [PIN_N-1:0] prevB;
    logic ctrlLr;
    logic ctrlKpDis;
    logic ctrlLrDin;
    logic [1:0] localSrc;
    logic [1:0] remoteSrc;
    logic serStart;
    logic serStop;
    logic [9:0] initPct;
    logic [9:0] maxPct;
    logic [15:0] full_load_amps_setting;
    logic [8:0] rampSec;
    logic [8:0] utsSec;
    ssc_mode_type mode;
    logic [TW-1:0] tickCnt;
    logic [9:0] msCnt;
    logic [8:0] secCnt;
    logic [18:0] rampMs;
    logic [19:0] acc;
    logic [9:0] pct;
    logic [19:0] curRef;
    logic [1:0] srcAct;
    logic remAct;
    logic [31:0] rdata;
  } ssc_state_type;

  ssc_state_type st;
  ssc_state_type next_st;
  logic [1:0] rstSync;
  logic rstLocal_n;

  // async assert, release only after two clean edges
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstSync <= 2'h0;
    end
    else
    begin
      rstSync <= {rstSync[0], 1'h1};
    end
  end
  assign rstLocal_n = rstSync[1];

  logic wrEn;
  logic rdSetup;
  logic mapped;
  logic badWrite;
  logic [9:0] wPct;
  logic [8:0] wSec;
  logic [1:0] wLoc;
  logic [1:0] wRem;
  logic [PIN_N-1:0] rise;
  logic remoteSel;
  logic [1:0] src;
  logic startCmd;
  logic stopCmd;
  logic [18:0] rampTarget;
  logic [9:0] diff;
  logic [19:0] accSum;
  logic tick;
  logic secTick;
  logic [25:0] prod;

  always_comb
  begin
    wPct = pwdata[9:0];
    wSec = pwdata[8:0];
    wLoc = pwdata[`SSC_SRC_LOCAL_LSB+:2];
    wRem = pwdata[`SSC_SRC_REMOTE_LSB+:2];
    mapped = 1'h1;
    badWrite = 1'h0;
    case (paddr)
      `SSC_OFF_CTRL, `SSC_OFF_CMD, `SSC_OFF_FLA: badWrite = 1'h0;
      `SSC_OFF_SOURCE: badWrite = wLoc > `SSC_SRC_SERIAL || wRem > `SSC_SRC_SERIAL;
      `SSC_OFF_INIT_CUR: badWrite = wPct < `SSC_INIT_PCT_MIN || wPct > `SSC_INIT_PCT_MAX;
      `SSC_OFF_MAX_CUR: badWrite = wPct < `SSC_MAX_PCT_MIN || wPct > `SSC_MAX_PCT_MAX;
      `SSC_OFF_RAMP_TIME: badWrite = wSec > `SSC_RAMP_SEC_MAX;
      `SSC_OFF_UTS_TIME: badWrite = wSec < `SSC_UTS_SEC_MIN || wSec > `SSC_UTS_SEC_MAX;
      `SSC_OFF_STATUS, `SSC_OFF_CUR_REF: badWrite = 1'h1;
      default: mapped = 1'h0;
    endcase
  end

  // zero wait states; out-of-range values leave the register untouched
  assign pready = 1'h1;
  assign pslverr = psel && penable && (!mapped || (pwrite && badWrite));
  assign wrEn = psel && penable && pwrite && mapped && !badWrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign prdata = st.rdata;

  assign rise = st.syncB & ~st.prevB;
  assign tick = st.tickCnt == TW'(TICK_CYCLES - 1);
  assign secTick = tick && st.msCnt == 10'(MS_PER_S - 1);
  assign rampTarget = 19'(st.rampSec * MS_PER_S);
  // an initial level at or above maximum gives a flat ramp
  assign diff = (st.maxPct > st.initPct) ? st.maxPct - st.initPct : 10'h000;
  assign prod = 26'(st.full_load_amps_setting) * 26'(st.pct);

  always_comb
  begin
    remoteSel = st.ctrlLrDin ? st.syncB[P_LR] : st.ctrlLr;
    src = remoteSel ? st.remoteSrc : st.localSrc;
    case (src)
      `SSC_SRC_KEYPAD:
      begin
        startCmd = rise[P_KSTA];
        stopCmd = rise[P_KSTO];
      end
      `SSC_SRC_TERMINAL:
      begin
        startCmd = rise[P_TSTA];
        stopCmd = rise[P_TSTO];
      end
      default:
      begin
        startCmd = st.serStart;
        stopCmd = st.serStop;
      end
    endcase
    if (!st.ctrlKpDis && rise[P_KSTO])
    begin
      stopCmd = 1'h1;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.syncA = {tripIn, atSpeed, terminalStop, terminalStart,
                     keypadStopKey, keypadStartKey, localRemoteIn};
    next_st.syncB = st.syncA;
    next_st.prevB = st.syncB;
    next_st.serStart = 1'h0;
    next_st.serStop = 1'h0;
    next_st.remAct = remoteSel;
    next_st.srcAct = src;
    accSum = st.acc;
    if (rdSetup)
    begin
      case (paddr)
        `SSC_OFF_CTRL: next_st.rdata = {29'h0, st.ctrlLrDin, st.ctrlKpDis, st.ctrlLr};
        `SSC_OFF_SOURCE: next_st.rdata = {26'h0, st.remoteSrc, 2'h0, st.localSrc};
        `SSC_OFF_INIT_CUR: next_st.rdata = {22'h0, st.initPct};
        `SSC_OFF_MAX_CUR: next_st.rdata = {22'h0, st.maxPct};
        `SSC_OFF_FLA: next_st.rdata = {16'h0, st.full_load_amps_setting};
        `SSC_OFF_RAMP_TIME: next_st.rdata = {23'h0, st.rampSec};
        `SSC_OFF_UTS_TIME: next_st.rdata = {23'h0, st.utsSec};
        `SSC_OFF_STATUS: next_st.rdata = {16'h0, st.pct, remoteSel, src, st.mode};
        `SSC_OFF_CUR_REF: next_st.rdata = {12'h0, st.curRef};
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (wrEn)
    begin
      case (paddr)
        `SSC_OFF_CTRL:
        begin
          next_st.ctrlLr = pwdata[`SSC_CTRL_LR_BIT];
          next_st.ctrlKpDis = pwdata[`SSC_CTRL_KPDIS_BIT];
          next_st.ctrlLrDin = pwdata[`SSC_CTRL_LRDIN_BIT];
        end
        `SSC_OFF_SOURCE:
        begin
          next_st.localSrc = wLoc;
          next_st.remoteSrc = wRem;
        end
        `SSC_OFF_CMD:
        begin
          next_st.serStart = pwdata[`SSC_CMD_START_BIT];
          next_st.serStop = pwdata[`SSC_CMD_STOP_BIT];
        end
        `SSC_OFF_INIT_CUR: next_st.initPct = wPct;
        `SSC_OFF_MAX_CUR: next_st.maxPct = wPct;
        `SSC_OFF_FLA: next_st.full_load_amps_setting = pwdata[15:0];
        `SSC_OFF_RAMP_TIME: next_st.rampSec = wSec;
        `SSC_OFF_UTS_TIME: next_st.utsSec = wSec;
        default: next_st.full_load_amps_setting = st.full_load_amps_setting;
      endcase
    end
    // free-running timebase in every mode; cleared when a start is taken
    next_st.tickCnt = tick ? '0 : TW'(st.tickCnt + 1'b1);
    if (tick)
    begin
      next_st.msCnt = secTick ? 10'h000 : 10'(st.msCnt + 1'b1);
    end
    if (secTick && st.secCnt != 9'h1ff)
    begin
      next_st.secCnt = 9'(st.secCnt + 1'b1);
    end
    case (st.mode)
      SSC_IDLE, SSC_STALLED, SSC_TRIPPED:
      begin
        next_st.pct = 10'h000;
        if (!stopCmd && startCmd)
        begin
          next_st.mode = SSC_RAMP;
          next_st.pct = st.initPct;
          next_st.acc = 20'h0;
          next_st.rampMs = 19'h0;
          next_st.tickCnt = '0;
          next_st.msCnt = 10'h000;
          next_st.secCnt = 9'h000;
        end
      end
      SSC_RAMP:
      begin
        // fractional steps carried so the slope is exact and never reverses
        accSum = tick ? 20'(st.acc + diff) : st.acc;
        next_st.acc = accSum;
        if (accSum >= 20'(rampTarget) && st.pct < st.maxPct)
        begin
          next_st.pct = 10'(st.pct + 1'b1);
          next_st.acc = 20'(accSum - 20'(rampTarget));
        end
        if (tick)
        begin
          next_st.rampMs = 19'(st.rampMs + 1'b1);
        end
        if (st.syncB[P_SPD])
        begin
          next_st.mode = SSC_RUN;
          next_st.pct = st.maxPct;
        end
        else if (st.rampMs >= rampTarget)
        begin
          next_st.mode = SSC_HOLD;
          next_st.pct = st.maxPct;
        end
      end
      SSC_HOLD:
      begin
        next_st.pct = st.maxPct;
        if (st.syncB[P_SPD])
        begin
          next_st.mode = SSC_RUN;
        end
      end
      SSC_RUN: next_st.pct = st.maxPct;
      default: next_st.mode = SSC_IDLE;
    endcase
    if (st.mode == SSC_RAMP || st.mode == SSC_HOLD)
    begin
      if (!st.syncB[P_SPD] && st.secCnt >= st.utsSec)
      begin
        next_st.mode = SSC_STALLED;
        next_st.pct = 10'h000;
      end
    end
    if (st.mode == SSC_RAMP || st.mode == SSC_HOLD || st.mode == SSC_RUN)
    begin
      if (st.syncB[P_TRIP])
      begin
        next_st.mode = SSC_TRIPPED;
        next_st.pct = 10'h000;
      end
      else if (stopCmd)
      begin
        next_st.mode = SSC_IDLE;
        next_st.pct = 10'h000;
      end
    end
    else if (stopCmd)
    begin
      next_st.mode = SSC_IDLE;
    end
    // one cycle behind pct; constant divide stays off the ramp path
    next_st.curRef = 20'(prod / `SSC_PCT_FULL);
  end

  always_ff @(posedge clock or negedge rstLocal_n)
  begin
    if (!rstLocal_n)
    begin
      st <= '0;
      st.ctrlLr <= `SSC_LR_LOCAL;
      st.localSrc <= `SSC_SRC_TERMINAL;
      st.remoteSrc <= `SSC_SRC_TERMINAL;
      st.initPct <= `SSC_INIT_PCT_RST;
      st.maxPct <= `SSC_MAX_PCT_RST;
      st.full_load_amps_setting <= `SSC_FLA_RST;
      st.rampSec <= `SSC_RAMP_SEC_RST;
      st.utsSec <= `SSC_UTS_SEC_RST;
      st.mode <= SSC_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign motorRun = st.mode == SSC_RAMP || st.mode == SSC_HOLD || st.mode == SSC_RUN;
  assign upToSpeed = st.mode == SSC_RUN;
  assign stalled = st.mode == SSC_STALLED;
  assign tripped = st.mode == SSC_TRIPPED;
  assign remoteActive = st.remAct;
  assign activeSource = st.srcAct;
  assign currentRef = st.curRef;
endmodule // ssc_starter

// ---- verif/ssc_motor_model.sv ----
`timescale 1ns/1ps
module ssc_motor_model
(
  input wire logic clock,
  input wire logic motorRun,
  input wire logic fast,
  input wire logic trip,
  output logic atSpeed,
  output logic tripIn
);
  logic [5:0] spin = 6'h00;
  // a slow load never comes up, so the stall path gets exercised
  always_ff @(posedge clock)
    spin <= !motorRun ? 6'h00 : (spin == 6'h3f ? spin : spin + 6'h01);
  assign atSpeed = fast && spin >= 6'h14;
  assign tripIn = trip;
endmodule // ssc_motor_model

// ---- verif/ssc_starter_chk.sv ----
`timescale 1ns/1ps
module ssc_starter_chk
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic atSpeed,
  input wire logic tripIn,
  input wire logic motorRun,
  input wire logic upToSpeed,
  input wire logic stalled,
  input wire logic tripped,
  input wire logic [1:0] activeSource,
  input wire logic [19:0] currentRef
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready)
    else $error("pready low");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err)
    else $error("pslverr outside access");
  property p_run; upToSpeed |-> motorRun; endproperty
  a_run: assert property (p_run)
    else $error("up to speed but not running");
  property p_off; $fell(motorRun) |=> currentRef == 20'h0; endproperty
  a_off: assert property (p_off)
    else $error("current left after stop");
  // ramp and hold never step the reference down while the initial level is at or below maximum
  property p_mono; motorRun && $past(motorRun) |-> currentRef >= $past(currentRef); endproperty
  a_mono: assert property (p_mono)
    else $error("reference fell while running");
  property p_speed; (motorRun && atSpeed && !tripIn) [*5] |-> upToSpeed; endproperty
  a_speed: assert property (p_speed)
    else $error("at speed not taken");
  property p_stall; $rose(stalled) |-> $past(motorRun) && !$past(upToSpeed); endproperty
  a_stall: assert property (p_stall)
    else $error("stall from wrong mode");
  // two sync flops, then the mode flop; only a running motor can trip
  property p_trip; tripIn ##2 motorRun |=> tripped; endproperty
  a_trip: assert property (p_trip)
    else $error("trip not taken");
  property p_src; activeSource != 2'h3; endproperty
  a_src: assert property (p_src)
    else $error("bad source code");
  c_stall: cover property (stalled);
  c_run: cover property (upToSpeed);
  c_trip: cover property (tripped);
endmodule // ssc_starter_chk
bind ssc_starter ssc_starter_chk u_chk (.*);

// ---- verif/tb_ssc_starter.sv ----
`timescale 1ns/1ps
module tb_ssc_starter;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [11:0] d;
    logic [11:0] q;
    logic e;
  } ssc_row_type;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic localRemoteIn = 1'b0;
  logic keypadStartKey = 1'b0;
  logic fast = 1'b0;
  logic trip = 1'b0;
  logic [2:0] btn = 3'h0;
  wire logic terminalStart = btn[0];
  wire logic terminalStop = btn[1];
  wire logic keypadStopKey = btn[2];
  logic [31:0] prdata;
  logic pready, pslverr, atSpeed, tripIn, motorRun, upToSpeed, stalled, tripped;
  logic remoteActive;
  logic [1:0] activeSource;
  logic [19:0] currentRef;
  wire logic [3:0] st = {tripped, stalled, upToSpeed, motorRun};
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int compares = 0;
  ssc_row_type rows [18] = '{
    '{1'b0, 8'h00, 12'h000, 12'h000, 1'b0},
    '{1'b0, 8'h04, 12'h000, 12'h011, 1'b0},
    '{1'b0, 8'h0c, 12'h000, 12'h064, 1'b0},
    '{1'b0, 8'h10, 12'h000, 12'h258, 1'b0},
    '{1'b0, 8'h20, 12'h000, 12'h008, 1'b0},
    '{1'b1, 8'h0c, 12'h031, 12'h000, 1'b1},
    '{1'b1, 8'h0c, 12'h259, 12'h000, 1'b1},
    '{1'b1, 8'h10, 12'h063, 12'h000, 1'b1},
    '{1'b1, 8'h10, 12'h321, 12'h000, 1'b1},
    '{1'b1, 8'h0c, 12'h032, 12'h000, 1'b0},
    '{1'b0, 8'h0c, 12'h000, 12'h032, 1'b0},
    '{1'b1, 8'h10, 12'h320, 12'h000, 1'b0},
    '{1'b0, 8'h10, 12'h000, 12'h320, 1'b0},
    '{1'b1, 8'h24, 12'h000, 12'h000, 1'b1},
    '{1'b0, 8'h28, 12'h000, 12'h000, 1'b1},
    '{1'b1, 8'h14, 12'h0c8, 12'h000, 1'b0},
    '{1'b1, 8'h18, 12'h001, 12'h000, 1'b0},
    '{1'b1, 8'h1c, 12'h002, 12'h000, 1'b0}
  };
  ssc_starter #(.TICK_CYCLES(10), .MS_PER_S(4)) dut (.*);
  ssc_motor_model u_motor (.*);
  always #4 clock = ~clock;
  task automatic report_and_stop;
    $display("checks %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic hang;
    n_fail++;
    $display("CHECK FAILED wait expected done seen timeout");
    report_and_stop;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      i++;
      if (i > 50)
        hang;
      @(posedge clock);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // polls on the falling edge so flop updates have landed
  task automatic waitst(input int b, input logic v);
    int i;
    i = 0;
    @(negedge clock);
    while (st[b] !== v)
    begin
      i++;
      if (i > 400)
        hang;
      @(negedge clock);
    end
    @(posedge clock);
  endtask
  task automatic press(input int k);
    btn[k] <= 1'b1;
    repeat (4) @(posedge clock);
    btn[k] <= 1'b0;
    @(posedge clock);
  endtask
  initial
  begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, 32'(rows[i].d));
      chk("pslverr", 32'(rows[i].e), 32'(er));
      if (rows[i].w === 1'b0)
        chk("prdata", 32'(rows[i].q), rd);
    end
    $display("register table done");
    press(0);
    waitst(0, 1'b1);
    @(negedge clock);
    chk("initial ref", 32'd100, 32'(currentRef));
    repeat (52) @(negedge clock);
    chk("hold ref", 32'd1600, 32'(currentRef));
    chk("hold run", 32'h1, 32'(motorRun));
    waitst(2, 1'b1);
    @(negedge clock);
    chk("stall ref", 32'h0, 32'(currentRef));
    $display("slow start done");
    @(posedge clock);
    fast <= 1'b1;
    press(0);
    waitst(1, 1'b1);
    @(negedge clock);
    chk("run ref", 32'd1600, 32'(currentRef));
    @(posedge clock);
    press(2);
    waitst(0, 1'b0);
    fast <= 1'b0;
    press(0);
    waitst(0, 1'b1);
    trip <= 1'b1;
    waitst(3, 1'b1);
    trip <= 1'b0;
    press(1);
    waitst(3, 1'b0);
    $display("fast start and trip done");
    apb(1'b1, 8'h04, 32'h21);
    apb(1'b1, 8'h00, 32'h1);
    repeat (3) @(negedge clock);
    chk("remote", 32'h1, 32'(remoteActive));
    chk("source", 32'h2, 32'(activeSource));
    @(posedge clock);
    press(0);
    @(negedge clock);
    chk("pin start", 32'h0, 32'(motorRun));
    @(posedge clock);
    apb(1'b1, 8'h08, 32'h1);
    waitst(0, 1'b1);
    apb(1'b1, 8'h08, 32'h2);
    waitst(0, 1'b0);
    apb(1'b1, 8'h00, 32'h5);
    repeat (4) @(negedge clock);
    chk("pin low", 32'h0, 32'(remoteActive));
    @(posedge clock);
    localRemoteIn <= 1'b1;
    repeat (6) @(negedge clock);
    chk("pin high", 32'h1, 32'(remoteActive));
    $display("source select done");
    @(posedge clock);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h20);
    keypadStartKey <= 1'b1;
    repeat (4) @(posedge clock);
    keypadStartKey <= 1'b0;
    waitst(0, 1'b1);
    @(negedge clock);
    chk("keypad source", 32'h0, 32'(activeSource));
    @(posedge clock);
    press(2);
    waitst(0, 1'b0);
    apb(1'b1, 8'h04, 32'h21);
    apb(1'b1, 8'h00, 32'h2);
    press(0);
    waitst(0, 1'b1);
    press(2);
    repeat (2) @(negedge clock);
    chk("stop disabled", 32'h1, 32'(motorRun));
    @(posedge clock);
    press(1);
    waitst(0, 1'b0);
    $display("keypad cases done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    $display("reset done");
    report_and_stop;
  end
endmodule // tb_ssc_starter
